// ===== eic_pkg.sv
/*
  Constants for the external interrupt conditioner: control register
  address and field layout, trigger encodings and filter timing.
  Assumes the core clock i_clk is the high-frequency clock and that
  the low-frequency clock is derived from it by a divider.
*/
// Summary of operation
// - six external inputs, each with its own noise filter before detection
// - after reset the shared input-zero pin acts as plain port bit ten
// - control bit 6: 0 port use, 1 interrupt input zero
// - with pin function 0, falling edges on input zero set no latch
// - inputs zero and five: falling edge only; reject <2, accept >=7 fc
// - control bits 1..3 select edge of inputs one..three: 0 rise, 1 fall
// - input four trigger: 00 rise, 01 fall, 10 both, 11 high level
// - control bit 7 sets input one rejection: 0 below 63, 1 below 15 fc
// - input one accepts 49 fc (short) or 193 fc (long) pulses
// - inputs two to four reject <7 fc and accept >=25 fc
// - low-speed modes: all filters reject <1 fs, accept >=3.5 fs
// - clean edge sets latch within acceptance time plus 6 fs
// - new input-one noise time takes effect within 64 fc
// - level trigger after reset needs a rising edge before requesting
// - pin output changes on a shared pin may raise spurious requests
// - latches are sampled in the last cycle of each instruction
package eic_pkg;
  localparam logic [5:0] CTRL_ADDR = 6'h37;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hFE;
  localparam int IN1_EDGE_BIT = 1;
  localparam int IN2_EDGE_BIT = 2;
  localparam int IN3_EDGE_BIT = 3;
  localparam int IN4_TRIG_LSB = 4;
  localparam int IN0_FUNC_BIT = 6;
  localparam int IN1_NOISE_BIT = 7;
  localparam logic [1:0] TRIG_RISE = 2'h0;
  localparam logic [1:0] TRIG_FALL = 2'h1;
  localparam logic [1:0] TRIG_BOTH = 2'h2;
  localparam logic [1:0] TRIG_HIGH = 2'h3;
  localparam int NUM_INPUTS = 6;
  // i_clk is the high-frequency clock, so one fc period per cycle
  localparam int CLK_HZ = 125000000;
  localparam int FC_PER_CLK = 1;
  localparam int LOW_FREQ_HZ = 32768;
  localparam logic [11:0] FS_TICK_CYC = 12'(CLK_HZ / LOW_FREQ_HZ);
  // acceptance times in fc periods
  localparam int IN05_ACCEPT_FC = 7;
  localparam int IN1_SHORT_ACCEPT_FC = 49;
  localparam int IN1_LONG_ACCEPT_FC = 193;
  localparam int IN234_ACCEPT_FC = 25;
  // low-speed acceptance time in tenths of fs periods
  localparam int SLOW_ACCEPT_FS_X10 = 35;
  localparam logic [7:0] IN05_CYC = 8'(IN05_ACCEPT_FC / FC_PER_CLK);
  localparam logic [7:0] IN1_SHORT_CYC = 8'(IN1_SHORT_ACCEPT_FC / FC_PER_CLK);
  localparam logic [7:0] IN1_LONG_CYC = 8'(IN1_LONG_ACCEPT_FC / FC_PER_CLK);
  localparam logic [7:0] IN234_CYC = 8'(IN234_ACCEPT_FC / FC_PER_CLK);
  localparam logic [7:0] SLOW_TICKS = 8'(SLOW_ACCEPT_FS_X10 / 10);
  // pins are primed once the synchroniser holds real pin data
  localparam logic [1:0] STARTUP_PRIME = 2'h2;
  localparam logic [1:0] STARTUP_DONE = 2'h3;
endpackage

// ===== eic_noise_filter.sv
/*
  One digital noise filter: except while primed, the output follows the input only after the
  input has differed from it on a given number of consecutive ticks.
  Assumes i_in is already synchronised to i_clk.
*/
`timescale 1ns/1ps
module eic_noise_filter
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_prime,
  input wire logic i_in,
  input wire logic [7:0] i_thresh,
  output logic o_level
);
  logic level_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_inc;
  wire differs = i_in != level_reg;
  wire accept = (cnt_inc >= i_thresh);

  assign cnt_inc = cnt_reg + 8'h01;
  assign o_level = level_reg;

  // threshold is compared live, so a new noise time applies at once
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      level_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end
    else if (i_prime)
    begin
      level_reg <= i_in;
      cnt_reg <= 8'h00;
    end
    else if (i_tick)
    begin
      // a shorter run restarts the count, so the pulse is dropped
      if (!differs)
        cnt_reg <= 8'h00;
      else if (accept)
      begin
        level_reg <= i_in;
        cnt_reg <= 8'h00;
      end
      else
        cnt_reg <= cnt_inc;
    end
  end
endmodule

// ===== eic_conditioner.sv
/*
  External interrupt conditioner: six pins are synchronised, filtered,
  edge or level detected and latched as interrupt requests. The control
  register sits on the special-function register port.
  Assumes the acceptance logic pulses i_latch_clr, the core marks the
  last cycle of each instruction, and i_low_speed_mode comes from logic
  on i_clk.
*/
`timescale 1ns/1ps
module eic_conditioner
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_ext_irq_pins,
  input wire logic i_low_speed_mode,
  input wire logic [5:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic [5:0] i_latch_clr,
  input wire logic i_instr_last_cycle,
  output logic [5:0] o_irq_latch,
  output logic [5:0] o_irq_sampled,
  output logic o_in0_pin_is_irq
);
  //////////////////////////////////////////////////////////////////////
  // registers and decode
  logic [7:0] ctrl_reg;
  logic [7:0] rdata_reg;
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [5:0] prev_reg;
  logic [5:0] latch_reg;
  logic [5:0] sampled_reg;
  logic [11:0] fs_cnt_reg;
  logic fs_tick_reg;
  logic [1:0] startup_reg;
  logic in4_armed_reg;
  logic in0_func_reg;
  logic [5:0] filt;
  logic [5:0] rise;
  logic [5:0] fall;
  logic [5:0] ev;
  logic [5:0] latch_next;
  logic [7:0] thresh [6];
  logic [1:0] in4_trig;

  wire sel = i_sfr_addr == eic_pkg::CTRL_ADDR;
  wire wr_ctrl = i_sfr_wr && sel;
  wire rd_ctrl = i_sfr_rd && sel;
  wire prime = startup_reg == eic_pkg::STARTUP_PRIME;
  wire running = startup_reg == eic_pkg::STARTUP_DONE;
  wire fs_wrap = fs_cnt_reg == (eic_pkg::FS_TICK_CYC - 12'h001);
  wire tick = i_low_speed_mode ? fs_tick_reg : 1'b1;
  wire [7:0] in1_fast = ctrl_reg[eic_pkg::IN1_NOISE_BIT] ?
                        eic_pkg::IN1_SHORT_CYC : eic_pkg::IN1_LONG_CYC;

  //////////////////////////////////////////////////////////////////////
  // filter thresholds: fast counts in fc, low-speed counts in fs ticks
  assign thresh[0] = i_low_speed_mode ? eic_pkg::SLOW_TICKS :
                     eic_pkg::IN05_CYC;
  assign thresh[5] = thresh[0];
  assign thresh[1] = i_low_speed_mode ? eic_pkg::SLOW_TICKS :
                     in1_fast;
  assign thresh[2] = i_low_speed_mode ? eic_pkg::SLOW_TICKS :
                     eic_pkg::IN234_CYC;
  assign thresh[3] = thresh[2];
  assign thresh[4] = thresh[2];

  // filters see the pin whatever its port direction, so output toggling
  // on a shared pin can still be taken as a request
  for (genvar k = 0; k < eic_pkg::NUM_INPUTS; k++)
  begin : g_filt
    eic_noise_filter u_filt
    (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_tick(tick),
      .i_prime(prime),
      .i_in(sync2_reg[k]),
      .i_thresh(thresh[k]),
      .o_level(filt[k])
    );
  end

  //////////////////////////////////////////////////////////////////////
  // detection
  assign rise = filt & ~prev_reg;
  assign fall = ~filt & prev_reg;
  assign in4_trig = ctrl_reg[eic_pkg::IN4_TRIG_LSB +: 2];

  assign ev[0] = running && fall[0] && in0_func_reg;
  assign ev[1] = running && (ctrl_reg[eic_pkg::IN1_EDGE_BIT] ?
                 fall[1] : rise[1]);
  assign ev[2] = running && (ctrl_reg[eic_pkg::IN2_EDGE_BIT] ?
                 fall[2] : rise[2]);
  assign ev[3] = running && (ctrl_reg[eic_pkg::IN3_EDGE_BIT] ?
                 fall[3] : rise[3]);
  assign ev[4] = running &&
    ((in4_trig == eic_pkg::TRIG_RISE && rise[4]) ||
     (in4_trig == eic_pkg::TRIG_FALL && fall[4]) ||
     (in4_trig == eic_pkg::TRIG_BOTH && (rise[4] || fall[4])) ||
     (in4_trig == eic_pkg::TRIG_HIGH && filt[4] &&
      in4_armed_reg));
  assign ev[5] = running && fall[5];

  // set wins over a clear in the same cycle
  assign latch_next = (latch_reg & ~i_latch_clr) | ev;

  assign o_sfr_rdata = rdata_reg;
  assign o_irq_latch = latch_reg;
  assign o_irq_sampled = sampled_reg;
  assign o_in0_pin_is_irq = in0_func_reg;

  //////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ctrl_reg <= eic_pkg::CTRL_RESET;
      in0_func_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= i_sfr_wdata & eic_pkg::CTRL_WMASK;
      in0_func_reg <= ctrl_reg[eic_pkg::IN0_FUNC_BIT];
      rdata_reg <= rd_ctrl ? ctrl_reg : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pins, low-frequency tick and start-up priming
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      fs_cnt_reg <= 12'h000;
      fs_tick_reg <= 1'b0;
      startup_reg <= 2'h0;
    end
    else
    begin
      sync1_reg <= i_ext_irq_pins;
      sync2_reg <= sync1_reg;
      fs_cnt_reg <= fs_wrap ? 12'h000 : fs_cnt_reg + 12'h001;
      fs_tick_reg <= fs_wrap;
      if (!running)
        startup_reg <= startup_reg + 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // latches and sampling
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      prev_reg <= 6'h00;
      latch_reg <= 6'h00;
      sampled_reg <= 6'h00;
      in4_armed_reg <= 1'b0;
    end
    else
    begin
      // priming copies the pin level so a pin high at reset is no edge
      prev_reg <= prime ? sync2_reg : filt;
      latch_reg <= latch_next;
      if (running && rise[4])
        in4_armed_reg <= 1'b1;
      if (i_instr_last_cycle)
        sampled_reg <= latch_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_in0_differs;
    (running && !i_low_speed_mode && sync2_reg[0] != filt[0])[*7];
  endsequence

  sequence s_in4_new_edge;
    running ##0 (rise[4] || fall[4]);
  endsequence

  AST_RESET_PORT_USE:
    assert property ($past(!i_rst_n) |-> ctrl_reg == eic_pkg::CTRL_RESET
                     && !o_in0_pin_is_irq)
      else $error("control not cleared after reset");
  AST_IN0_GATED:
    assert property ($rose(o_irq_latch[0]) |-> $past(in0_func_reg))
      else $error("input zero latched in port mode");
  AST_IN0_ACCEPT:
    assert property (s_in0_differs |=> $changed(filt[0]))
      else $error("input zero filter missed a long pulse");
  AST_IN5_FALL_ONLY:
    assert property ($rose(o_irq_latch[5]) |-> $past(prev_reg[5])
                     && !$past(filt[5]))
      else $error("input five latched without falling edge");
  AST_EDGE_SEL:
    assert property ($rose(o_irq_latch[1]) |->
                     ($past(ctrl_reg[eic_pkg::IN1_EDGE_BIT]) ?
                      $past(fall[1]) : $past(rise[1])))
      else $error("input one latched on wrong edge");
  AST_IN4_BOTH:
    assert property (s_in4_new_edge ##0 in4_trig == eic_pkg::TRIG_BOTH
                     |=> o_irq_latch[4])
      else $error("input four missed an edge in both-edge mode");
  AST_IN4_ARMED:
    assert property ($rose(o_irq_latch[4]) &&
                     $past(in4_trig) == eic_pkg::TRIG_HIGH |->
                     $past(in4_armed_reg))
      else $error("level request before first rising edge");
  AST_SET_WINS:
    assert property ((ev & i_latch_clr) != 6'h00 |=>
                     (o_irq_latch & $past(ev)) == $past(ev))
      else $error("event lost against a clear");
  AST_LATCH_STICKY:
    assert property (1'b1 |=> (o_irq_latch & $past(o_irq_latch) &
                     ~$past(i_latch_clr)) ==
                     ($past(o_irq_latch) & ~$past(i_latch_clr)))
      else $error("latch dropped without a clear");
  AST_SAMPLE:
    assert property (i_instr_last_cycle |=>
                     o_irq_sampled == $past(o_irq_latch))
      else $error("latch not sampled in last cycle");
endmodule

// ===== eic_pin_source.sv
/*
  Model of the signal sources on the six external interrupt pins.
  Assumes the bench sets steady levels and requests pulses on i_clk.
*/
`timescale 1ns/1ps
module eic_pin_source
(
  input wire logic i_clk,
  input wire logic [5:0] i_level,
  input wire logic [5:0] i_pulse_sel,
  input wire logic [15:0] i_pulse_len,
  input wire logic i_pulse_go,
  output logic [5:0] o_pins
);
  logic [15:0] left_reg = 16'h0000;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk)
  begin
    if (i_pulse_go)
      left_reg <= i_pulse_len;
    else if (left_reg != 16'h0000)
      left_reg <= left_reg - 16'h0001;
  end
  // exact widths matter: filter thresholds are tested one cycle apart
  assign o_pins = (left_reg != 16'h0000) ? (i_level ^ i_pulse_sel) : i_level;
endmodule

// ===== eic_conditioner_tb_top.sv
/*
  Self-checking bench for the external interrupt conditioner.
  Assumes eic_pin_source drives the pins and 3814 cycles per fs tick.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module eic_conditioner_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] lvl = 6'h21;
  logic [5:0] psel = 6'h00;
  logic [15:0] plen = 16'h0000;
  logic pgo = 1'b0;
  logic low = 1'b0;
  logic [5:0] addr = 6'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [5:0] clr = 6'h00;
  logic ilc = 1'b0;
  logic [7:0] rdata;
  logic [5:0] latch;
  logic [5:0] samp;
  logic isirq;
  logic [5:0] pins;
  logic [7:0] rv;
  int failures = 0;
  int tests_run = 0;
  logic [5:0] tsel [6] = '{6'h20, 6'h02, 6'h02, 6'h04, 6'h08, 6'h10};
  logic [7:0] tctl [6] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [15:0] tlen [6] = '{16'h6, 16'h30, 16'hC0, 16'h18, 16'h18, 16'h18};
  ////////////////////////////////////////////////////////////////////////
  eic_pin_source src_u (.i_clk(clk), .i_level(lvl), .i_pulse_sel(psel),
    .i_pulse_len(plen), .i_pulse_go(pgo), .o_pins(pins));
  eic_conditioner dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_ext_irq_pins(pins),
    .i_low_speed_mode(low), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_latch_clr(clr),
    .i_instr_last_cycle(ilc), .o_irq_latch(latch), .o_irq_sampled(samp),
    .o_in0_pin_is_irq(isirq));
  initial
  begin
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // waits twice the width plus ten cycles so the filter has settled back before returning
  task automatic pulse(input logic [5:0] s, input logic [15:0] n);
    @(posedge clk);
    psel <= s; plen <= n; pgo <= 1'b1;
    @(posedge clk);
    pgo <= 1'b0;
    tick(2 * int'(n) + 10);
  endtask
  task automatic clear_all();
    @(posedge clk);
    clr <= 6'h3F;
    @(posedge clk);
    clr <= 6'h00;
    tick(2);
  endtask
  task automatic setp(input int k, input logic v);
    @(posedge clk);
    lvl[k] <= v;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    tick(3);
    rst_n <= 1'b1;
    tick(5);
  endtask
  task automatic test_done();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rreg(6'h37, rv);
    `CHK(rv, 8'h00)
    `CHK(isirq, 1'b0)
    wreg(6'h37, 8'hFF);
    rreg(6'h37, rv);
    `CHK(rv, 8'hFE)
    wreg(6'h36, 8'h00);
    rreg(6'h37, rv);
    `CHK(rv, 8'hFE)
    rreg(6'h36, rv);
    `CHK(rv, 8'h00)
    wreg(6'h37, 8'h00);
    tick(64);
  endtask
  // one step below and exactly at each acceptance width
  task automatic t_thresh();
    for (int i = 0; i < 6; i++)
    begin
      wreg(6'h37, tctl[i]);
      tick(64);
      pulse(tsel[i], tlen[i]);
      `CHK(latch, 6'h00)
      pulse(tsel[i], tlen[i] + 16'h1);
      `CHK(latch, tsel[i])
      clear_all();
    end
  endtask
  task automatic t_in0();
    wreg(6'h37, 8'h00);
    pulse(6'h01, 16'hA);
    `CHK(latch, 6'h00)
    wreg(6'h37, 8'h40);
    tick(1);
    #1 `CHK(isirq, 1'b1)
    pulse(6'h01, 16'hA);
    `CHK(latch, 6'h01)
    @(posedge clk);
    ilc <= 1'b1;
    @(posedge clk);
    ilc <= 1'b0;
    #1 `CHK(samp, 6'h01)
    clear_all();
    `CHK(latch, 6'h00)
  endtask
  task automatic t_edges();
    for (int k = 1; k < 4; k++)
      for (int s = 0; s < 2; s++)
      begin
        wreg(6'h37, 8'(s << k));
        setp(k, 1'b1);
        tick(210);
        `CHK(latch, (s == 0) ? 6'(1 << k) : 6'h00)
        clear_all();
        setp(k, 1'b0);
        tick(210);
        `CHK(latch, (s == 1) ? 6'(1 << k) : 6'h00)
        clear_all();
      end
  endtask
  task automatic t_in4();
    setp(4, 1'b1);
    do_reset();
    wreg(6'h37, 8'h30);
    tick(40);
    `CHK(latch, 6'h00)
    setp(4, 1'b0);
    tick(40);
    setp(4, 1'b1);
    tick(40);
    `CHK(latch, 6'h10)
    setp(4, 1'b0);
    tick(40);
    clear_all();
    for (int m = 0; m < 4; m++)
    begin
      wreg(6'h37, 8'(m << 4));
      tick(64);
      setp(4, 1'b1);
      tick(40);
      `CHK(latch, (m != 1) ? 6'h10 : 6'h00)
      @(posedge clk);
      lvl[4] <= 1'b0; clr <= 6'h3F;
      @(posedge clk);
      clr <= 6'h00;
      tick(40);
      // high-level mode keeps setting while the filtered level is still high
      `CHK(latch, (m != 0) ? 6'h10 : 6'h00)
      clear_all();
      `CHK(latch, 6'h00)
    end
  endtask
  task automatic t_slow();
    wreg(6'h37, 8'h00);
    @(posedge clk);
    low <= 1'b1;
    // any request latched across the speed switch is cleared before the pulses
    clear_all();
    pulse(6'h20, 16'd3000);
    `CHK(latch, 6'h00)
    pulse(6'h20, 16'd15256);
    `CHK(latch, 6'h20)
    @(posedge clk);
    low <= 1'b0;
    clear_all();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(3);
    rst_n <= 1'b1;
    tick(5);
    t_regs();
    t_thresh();
    t_in0();
    t_edges();
    t_in4();
    t_slow();
    test_done();
  end
  initial
  begin
    repeat (80000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule
